//--- src/ebr_pkg.sv
// Purpose: shared constants and types of the ready-controlled bus cycle unit
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   phase counts are in bus reference clock periods
package ebr_pkg;

    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int REG_AW   = 4;
    localparam int REG_DW   = 32;
    localparam int PHASE_W  = 4;
    localparam int WCNT_W   = 8;

    // register offsets
    localparam logic [REG_AW-1:0] CTRL_OFS   = 4'h0;
    localparam logic [REG_AW-1:0] TIMING_OFS = 4'h4;
    localparam logic [REG_AW-1:0] STATUS_OFS = 4'h8;

    // control fields
    localparam int CTRL_POL_BIT   = 0;
    localparam int CTRL_ASYNC_BIT = 1;
    localparam int CTRL_RDYEN_BIT = 2;

    // timing fields
    localparam int TIM_ADDR_LSB = 0;
    localparam int TIM_WAIT_LSB = 4;
    localparam int TIM_W        = 8;

    // status fields
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_RDY_BIT   = 1;
    localparam int STAT_WCNT_LSB  = 8;

    // reset values
    localparam logic       CTRL_POL_RST   = 1'b0;
    localparam logic       CTRL_ASYNC_RST = 1'b0;
    localparam logic       CTRL_RDYEN_RST = 1'b0;
    localparam logic [7:0] TIM_RST        = 8'h11;

    typedef enum logic [2:0] {
        EBR_IDLE,
        EBR_ADDR,
        EBR_MWAIT,
        EBR_SYNCW,
        EBR_RDYCHK
    } ebr_state_t;

endpackage

//--- src/ebr_ready_sync.sv
// Purpose: polarity select and synchroniser for the ready pin
// Assumes: pin is asynchronous to clk
// Notes:   output moves only once stages two and three agree
`timescale 1ns/1ps
module ebr_ready_sync
    import ebr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ready_pin,
    input  wire logic ready_pol,
    output logic      ready_active
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } ebr_sync_t;

    ebr_sync_t q;
    ebr_sync_t d;

    always_comb
    begin
        d     = q;
        // polarity applied ahead of the first flop
        d.s1  = ready_pol ? ready_pin : ~ready_pin;
        d.s2  = q.s1;
        d.s3  = q.s2;
        // agreement filter blocks a single metastable resolution
        if (q.s2 == q.s3)
        begin
            d.out = q.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign ready_active = q.out;

endmodule

//--- src/ebr_ctrl.sv
// Purpose: external bus cycle sequencer with ready-controlled waitstates
// Assumes: bus reference clock is clk divided by two
// Notes:   timing latched per cycle; control bits act live
`timescale 1ns/1ps
module ebr_ctrl
    import ebr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    // register port
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [REG_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [REG_DW-1:0] reg_rdata,
    // bus cycle requests
    input  wire logic              req_valid,
    input  wire logic              req_we,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output logic                   cyc_done,
    output logic      [DATA_W-1:0] cyc_rdata,
    // external bus pins
    output logic                   bus_reference_clock_out,
    output logic      [ADDR_W-1:0] bus_addr,
    output logic                   bus_rd_b,
    output logic                   bus_wr_b,
    output logic      [DATA_W-1:0] bus_data_o,
    output logic                   bus_data_oe_b,
    input  wire logic [DATA_W-1:0] bus_data_i,
    input  wire logic              bus_ready_in
);

    typedef struct packed {
        ebr_state_t          st;
        logic                ref_clk;
        logic [PHASE_W-1:0]  cnt;
        logic [WCNT_W-1:0]   wcnt;
        logic [WCNT_W-1:0]   last_wcnt;
        logic                pol;
        logic                async_m;
        logic                rdy_en;
        logic [TIM_W-1:0]    tim;
        logic [TIM_W-1:0]    cyc_tim;
        logic                pend;
        logic                pend_we;
        logic [ADDR_W-1:0]   pend_addr;
        logic [DATA_W-1:0]   pend_wdata;
        logic                we;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic                rd_b;
        logic                wr_b;
        logic                oe_b;
        logic [DATA_W-1:0]   rdata;
        logic                done;
        logic [REG_DW-1:0]   reg_rdata;
    } ebr_main_t;

    ebr_main_t q;
    ebr_main_t d;

    logic async_rdy;
    logic sync_rdy;
    logic rdy_now;
    logic tick;

    function automatic logic [PHASE_W-1:0] phase_of(
        input logic [TIM_W-1:0] tim,
        input int               lsb
    );
        phase_of = tim[lsb +: PHASE_W];
    endfunction

    ebr_ready_sync u_sync (
        .clk          (clk),
        .rst_b        (rst_b),
        .ready_pin    (bus_ready_in),
        .ready_pol    (q.pol),
        .ready_active (async_rdy)
    );

    // sync mode relies on the partner timing ready to the ref clock
    assign sync_rdy = q.pol ? bus_ready_in : ~bus_ready_in;
    assign rdy_now  = q.async_m ? async_rdy : sync_rdy;
    // bus phases move where the reference clock rises
    assign tick     = ~q.ref_clk;

    always_comb
    begin
        d         = q;
        d.ref_clk = ~q.ref_clk;
        d.done    = 1'b0;
        d.reg_rdata = '0;

        if (reg_wr)
        begin
            if (reg_addr == CTRL_OFS)
            begin
                d.pol     = reg_wdata[CTRL_POL_BIT];
                d.async_m = reg_wdata[CTRL_ASYNC_BIT];
                d.rdy_en  = reg_wdata[CTRL_RDYEN_BIT];
            end
            else if (reg_addr == TIMING_OFS)
            begin
                d.tim = reg_wdata[TIM_W-1:0];
            end
        end

        if (reg_rd)
        begin
            case (reg_addr)
                CTRL_OFS:
                begin
                    d.reg_rdata[CTRL_POL_BIT]   = q.pol;
                    d.reg_rdata[CTRL_ASYNC_BIT] = q.async_m;
                    d.reg_rdata[CTRL_RDYEN_BIT] = q.rdy_en;
                end
                TIMING_OFS:
                begin
                    d.reg_rdata[TIM_W-1:0] = q.tim;
                end
                STATUS_OFS:
                begin
                    d.reg_rdata[STAT_BUSY_BIT] = q.pend
                        | (q.st != EBR_IDLE);
                    d.reg_rdata[STAT_RDY_BIT]  = rdy_now;
                    d.reg_rdata[STAT_WCNT_LSB +: WCNT_W] = q.last_wcnt;
                end
                default:
                begin
                    d.reg_rdata = '0;
                end
            endcase
        end

        if (req_valid && !q.pend && q.st == EBR_IDLE)
        begin
            d.pend       = 1'b1;
            d.pend_we    = req_we;
            d.pend_addr  = req_addr;
            d.pend_wdata = req_wdata;
        end

        if (tick)
        begin
            case (q.st)
                EBR_IDLE:
                begin
                    if (q.pend)
                    begin
                        d.pend    = 1'b0;
                        d.we      = q.pend_we;
                        d.addr    = q.pend_addr;
                        d.wdata   = q.pend_wdata;
                        d.oe_b    = ~q.pend_we;
                        d.cyc_tim = q.tim;
                        d.wcnt    = '0;
                        d.cnt     = phase_of(q.tim, TIM_ADDR_LSB);
                        d.st      = EBR_ADDR;
                    end
                end
                EBR_ADDR:
                begin
                    // a zero length still gives one address period
                    if (q.cnt <= 4'h1)
                    begin
                        d.rd_b = q.we;
                        d.wr_b = ~q.we;
                        d.cnt  = phase_of(q.cyc_tim, TIM_WAIT_LSB);
                        if (phase_of(q.cyc_tim, TIM_WAIT_LSB) != 4'h0)
                        begin
                            d.st = EBR_MWAIT;
                        end
                        else if (!q.rdy_en)
                        begin
                            d.st = EBR_RDYCHK;
                        end
                        else
                        begin
                            d.st = q.async_m ? EBR_SYNCW : EBR_RDYCHK;
                        end
                    end
                    else
                    begin
                        d.cnt = q.cnt - 4'h1;
                    end
                end
                EBR_MWAIT:
                begin
                    // ready is not looked at here
                    if (q.cnt == 4'h1)
                    begin
                        d.st = (q.rdy_en && q.async_m) ? EBR_SYNCW
                                                       : EBR_RDYCHK;
                    end
                    else
                    begin
                        d.cnt = q.cnt - 4'h1;
                    end
                end
                EBR_SYNCW:
                begin
                    // covers the synchroniser latency
                    d.wcnt = q.wcnt + 8'h01;
                    d.st   = EBR_RDYCHK;
                end
                EBR_RDYCHK:
                begin
                    if (!q.rdy_en || rdy_now)
                    begin
                        // read data and strobe rise on one edge
                        d.rdata     = q.we ? q.rdata : bus_data_i;
                        d.rd_b      = 1'b1;
                        d.wr_b      = 1'b1;
                        d.oe_b      = 1'b1;
                        d.addr      = '0;
                        d.done      = 1'b1;
                        d.last_wcnt = q.wcnt;
                        d.st        = EBR_IDLE;
                    end
                    else
                    begin
                        // saturate rather than wrap the wait counter
                        if (q.wcnt != 8'hFF)
                        begin
                            d.wcnt = q.wcnt + 8'h01;
                        end
                    end
                end
                default:
                begin
                    d.st = EBR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q         <= '0;
            q.st      <= EBR_IDLE;
            q.pol     <= CTRL_POL_RST;
            q.async_m <= CTRL_ASYNC_RST;
            q.rdy_en  <= CTRL_RDYEN_RST;
            q.tim     <= TIM_RST;
            q.rd_b    <= 1'b1;
            q.wr_b    <= 1'b1;
            q.oe_b    <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata               = q.reg_rdata;
    assign req_ready               = ~q.pend & (q.st == EBR_IDLE);
    assign cyc_done                = q.done;
    assign cyc_rdata               = q.rdata;
    assign bus_reference_clock_out = q.ref_clk;
    assign bus_addr                = q.addr;
    assign bus_rd_b                = q.rd_b;
    assign bus_wr_b                = q.wr_b;
    assign bus_data_o              = q.wdata;
    assign bus_data_oe_b           = q.oe_b;

endmodule

//--- sim/ebr_ctrl_assertions.sv
// Purpose: port checks of the ready-controlled bus cycle unit
// Assumes: control and timing change only between bus cycles
// Notes:   control and timing are shadowed from register writes
`timescale 1ns/1ps
module ebr_ctrl_chk
    import ebr_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              req_ready,
    input wire logic              cyc_done,
    input wire logic [DATA_W-1:0] cyc_rdata,
    input wire logic              bus_reference_clock_out,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic              bus_rd_b,
    input wire logic              bus_wr_b,
    input wire logic              bus_data_oe_b,
    input wire logic [DATA_W-1:0] bus_data_i,
    input wire logic              bus_ready_in
);
    logic [2:0] ctl_q;
    logic [3:0] mw_q;
    logic [3:0] tk_q;
    wire        off = bus_rd_b & bus_wr_b;
    wire        en  = ctl_q[CTRL_RDYEN_BIT];
    wire        asy = ctl_q[CTRL_ASYNC_BIT];
    wire        act = bus_ready_in == ctl_q[CTRL_POL_BIT];

    // ticks since the strobe fell, saturating
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_q <= 3'h0;
            mw_q  <= TIM_RST[7:4];
            tk_q  <= 4'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == CTRL_OFS)
                ctl_q <= reg_wdata[2:0];
            if (reg_wr && reg_addr == TIMING_OFS)
                mw_q <= reg_wdata[7:4];
            if (off)
                tk_q <= 4'h0;
            else if (!bus_reference_clock_out && tk_q != 4'hF)
                tk_q <= tk_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_done_pulse: assert property (cyc_done |=> !cyc_done)
        else $error("done too long");
    chk_rd_end: assert property ($rose(bus_rd_b) |->
        cyc_done && bus_reference_clock_out) else $error("read end wrong");
    chk_rd_data: assert property ($rose(bus_rd_b) |->
        cyc_rdata == $past(bus_data_i)) else $error("read data lost");
    chk_wr_end: assert property ($rose(bus_wr_b) |->
        cyc_done && bus_reference_clock_out) else $error("write end wrong");
    chk_not_ready: assert property (!off && en && !asy && !act
        |=> !off) else $error("ended without ready");
    chk_ready_ends: assert property (!off && en && !asy && act
        && !bus_reference_clock_out && tk_q >= mw_q |=> off)
        else $error("ready ignored");
    chk_mand_wait: assert property ($rose(off) && en |->
        tk_q > mw_q + 4'(asy)) else $error("ready used early");
    chk_addr_hold: assert property (!off && !$past(off) |->
        $stable(bus_addr)) else $error("address moved");
    chk_busy_refuse: assert property (!off |-> !req_ready)
        else $error("request taken mid cycle");
    chk_wr_drive: assert property (!bus_wr_b |-> !bus_data_oe_b)
        else $error("write data not driven");
    chk_rd_float: assert property (!bus_rd_b |-> bus_data_oe_b)
        else $error("data driven in read");
endmodule

bind ebr_ctrl ebr_ctrl_chk ebr_ctrl_chk_i (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .req_ready(req_ready), .cyc_done(cyc_done), .cyc_rdata(cyc_rdata),
    .bus_reference_clock_out(bus_reference_clock_out),
    .bus_addr(bus_addr), .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b),
    .bus_data_oe_b(bus_data_oe_b), .bus_data_i(bus_data_i),
    .bus_ready_in(bus_ready_in));

//--- sim/ebr_ready_model.sv
// Purpose: far-side circuit answering bus cycles with ready and data
// Assumes: fed only from registered bus outputs
// Notes:   ready comes dly clocks after a strobe falls
`timescale 1ns/1ps
module ebr_ready_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        rd_b,
    input  wire logic        wr_b,
    input  wire logic        pol,
    input  wire logic [7:0]  dly,
    input  wire logic [15:0] rdata,
    output logic             rdy,
    output logic [15:0]      dout
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            cnt_q <= 8'h00;
        else if (rd_b & wr_b)
            cnt_q <= 8'h00;
        else if (cnt_q != 8'hFF)
            cnt_q <= cnt_q + 8'h01;

    // held till the strobe rises, well past a period
    // dropped as the strobe rises, before the next sample
    assign rdy = (!(rd_b & wr_b) && cnt_q >= dly) ? pol : ~pol;
    // released bus shows the inverse, not the last value
    assign dout = rd_b ? ~rdata : rdata;
endmodule

//--- sim/tb_ebr_ctrl.sv
// Purpose: self-checking bench of the ready-controlled bus cycle unit
// Assumes: control changes only while the bus is idle
// Notes:   lat counts clocks from request taken to done
`timescale 1ns/1ps
`define CHECK_EQ(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_fail++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_ebr_ctrl
    import ebr_pkg::*;
;
    logic              clk = 1'b0, rst_b = 1'b0, pol = 1'b0;
    logic              reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
    logic              req_we = 1'b0;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [REG_DW-1:0] reg_wdata = '0, reg_rdata;
    logic [ADDR_W-1:0] req_addr = '0, bus_addr;
    logic [DATA_W-1:0] req_wdata = '0, rdat = '0, exp_rd = '0;
    logic [DATA_W-1:0] cyc_rdata, bus_data_i, bus_data_o;
    logic [7:0]        dly = 8'h00;
    logic              cyc_done, bus_reference_clock_out, bus_rd_b;
    logic              bus_wr_b, bus_ready_in;
    int                n_fail = 0, n_compared = 0, lat, lz, lt[4];

    ebr_ctrl ebr_ctrl_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .req_valid(req_valid), .req_we(req_we),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(),
        .cyc_done(cyc_done), .cyc_rdata(cyc_rdata),
        .bus_reference_clock_out(bus_reference_clock_out),
        .bus_addr(bus_addr), .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b),
        .bus_data_o(bus_data_o), .bus_data_oe_b(),
        .bus_data_i(bus_data_i), .bus_ready_in(bus_ready_in));
    ebr_ready_model ebr_ready_model_i (.clk(clk), .rst_b(rst_b),
        .rd_b(bus_rd_b), .wr_b(bus_wr_b), .pol(pol), .dly(dly),
        .rdata(rdat), .rdy(bus_ready_in), .dout(bus_data_i));

    initial
        forever #2 clk = ~clk;

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // a write must leave the read word at zero next cycle
    task automatic acc(input logic wr, input logic [REG_AW-1:0] a,
                       input logic [REG_DW-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= wr;
        reg_rd    <= !wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 `CHECK_EQ("reg_rdata", wr ? 32'h0 : d, reg_rdata)
    endtask

    task automatic cyc(input logic we, input logic [DATA_W-1:0] d,
                       input logic [7:0] dl);
        int i;
        logic [ADDR_W-1:0] ba;
        logic [DATA_W-1:0] wd;
        @(posedge clk);
        req_valid <= 1'b1;
        req_we    <= we;
        req_addr  <= {8'h00, d};
        req_wdata <= d;
        rdat      <= d;
        dly       <= dl;
        exp_rd    <= we ? exp_rd : d;
        @(posedge clk);
        req_valid <= 1'b0;
        lat = 0;
        for (i = 0; i < 200 && cyc_done !== 1'b1; i++)
        begin
            @(posedge clk);
            #1 lat++;
            // last address and write data seen while a strobe was low
            if (!(bus_rd_b & bus_wr_b))
                ba = bus_addr;
            if (!bus_wr_b)
                wd = bus_data_o;
        end
        `CHECK_EQ("cyc_done", 1'b1, cyc_done)
        `CHECK_EQ("cyc_rdata", exp_rd, cyc_rdata)
        `CHECK_EQ("bus_addr", {8'h00, d}, ba)
        if (we)
            `CHECK_EQ("bus_data_o", d, wd)
        if (i == 200)
            print_verdict;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        acc(1'b0, TIMING_OFS, 32'h11);
        acc(1'b0, CTRL_OFS, 32'h0);
        acc(1'b0, 4'hC, 32'h0);
        acc(1'b1, TIMING_OFS, 32'h11);
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b1, CTRL_OFS, 32'(k) | 32'h4);
            @(posedge clk);
            pol <= k[0];
            cyc(1'b0, 16'h5A00 ^ 16'(k), 8'h00);
            lt[k] = lat;
            cyc(1'b1, 16'hC300 ^ 16'(k), 8'h06);
            `CHECK_EQ("ready_wait", 1'b1, lat > lt[k])
            // sync: two inactive samples before the model answers
            if (k < 2)
                acc(1'b0, STATUS_OFS, 32'h200);
            $display("ready mode %0d done", k);
        end
        `CHECK_EQ("async_late", 1'b1, lt[2] > lt[0])
        `CHECK_EQ("async_late", 1'b1, lt[3] > lt[1])
        acc(1'b1, TIMING_OFS, 32'h21);
        acc(1'b1, CTRL_OFS, 32'h4);
        @(posedge clk);
        pol <= 1'b0;
        cyc(1'b0, 16'h0FF0, 8'h00);
        `CHECK_EQ("mand_wait", 1'b1, lat > lt[0])
        acc(1'b1, TIMING_OFS, 32'h01);
        cyc(1'b0, 16'h0F0F, 8'h00);
        `CHECK_EQ("no_mand_wait", 1'b1, lat < lt[0])
        lz = lat;
        acc(1'b1, CTRL_OFS, 32'h6);
        cyc(1'b0, 16'hF0F0, 8'h00);
        `CHECK_EQ("async_late", 1'b1, lat > lz)
        acc(1'b1, CTRL_OFS, 32'h0);
        cyc(1'b1, 16'h1234, 8'hFE);
        `CHECK_EQ("no_ready", 1'b1, lat < 20)
        $display("phase tests done");
        print_verdict;
    end
endmodule
